// >>> logic/bfau_core.sv
`default_nettype none
module bfau_core (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  // Instruction port
  input  wire logic                   op_valid_i,
  input  wire bfau_pkg::bfau_op_t     op_code_i,
  input  wire logic [3:0]             op_count_i,
  input  wire logic [1:0]             op_index_i,
  input  wire logic [15:0]            op_data_i,
  output logic                        op_ready_o,
  // Results
  output logic [15:0]                 acc_a_o,
  output logic [15:0]                 acc_b_o,
  output logic [63:0]                 first_bcd_acc_o,
  output logic [63:0]                 second_bcd_acc_o,
  output logic                        decimal_carry_flag_o,
  output logic                        skip_o,
  output logic                        done_o
);
  typedef enum logic {ST_IDLE, ST_MUL} bfau_fsm_t;

  typedef struct packed {
    bfau_fsm_t   fsm;
    logic [15:0] acc_a;
    logic [15:0] acc_b;
    logic [63:0] bcd_x;
    logic [63:0] bcd_y;
    logic        dcarry;
    logic        skip;
    logic        done;
    logic [33:0] prod;
    logic [16:0] mcand;
    logic [4:0]  step;
  } bfau_state_t;

  bfau_state_t state_r;
  bfau_state_t state_nxt;
  logic [47:0] comp_in;
  logic [47:0] comp_out;
  logic        op_fire;

  // Twelve-digit BCD add with carry in, returns carry and sum
  function automatic logic [48:0] bcd_add(input logic [47:0] a,
                                          input logic [47:0] b,
                                          input logic        cin);
    logic       c;
    logic [4:0] s;
    logic [47:0] r;
    c = cin;
    r = '0;
    s = 5'h00;
    for (int i = 0; i < bfau_pkg::NUM_DIGITS; i++) begin
      s = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
      if (s > 5'h09) begin
        s = s + 5'h06;
        c = 1'b1;
      end else begin
        c = 1'b0;
      end
      r[i*4 +: 4] = s[3:0];
    end
    return {c, r};
  endfunction

  assign op_fire    = op_valid_i && (state_r.fsm == ST_IDLE);
  assign op_ready_o = (state_r.fsm == ST_IDLE);

  // Complement source chosen by instruction
  assign comp_in = (op_code_i == bfau_pkg::OP_COMPLEMENT_SECOND_BCD_ACC) ?
                   state_r.bcd_y[47:0] : state_r.bcd_x[47:0];

  bfau_tens_comp #(
    .NUM_DIGITS (bfau_pkg::NUM_DIGITS)
  ) u_comp (
    .mant_i (comp_in),
    .comp_o (comp_out)
  );

  always_comb begin
    logic [16:0] upper;
    logic [48:0] sum;
    state_nxt      = state_r;
    state_nxt.skip = 1'b0;
    state_nxt.done = 1'b0;
    upper          = state_r.prod[33:17];
    sum            = bcd_add(state_r.bcd_x[47:0], state_r.bcd_y[47:0],
                             state_r.dcarry);
    case (state_r.fsm)
      ST_IDLE: begin
        if (op_fire) begin
          state_nxt.done = 1'b1;
          case (op_code_i)
            bfau_pkg::OP_LOAD_A: state_nxt.acc_a = op_data_i;
            bfau_pkg::OP_LOAD_B: state_nxt.acc_b = op_data_i;
            bfau_pkg::OP_LOAD_X: begin
              state_nxt.bcd_x[op_index_i*16 +: 16] = op_data_i;
            end
            bfau_pkg::OP_LOAD_Y: begin
              state_nxt.bcd_y[op_index_i*16 +: 16] = op_data_i;
            end
            bfau_pkg::OP_SHIFT_RIGHT_SIGNED_ACC_A: begin
              state_nxt.acc_a = $signed(state_r.acc_a) >>>
                                op_count_i;
            end
            bfau_pkg::OP_SHIFT_RIGHT_SIGNED_ACC_B: begin
              state_nxt.acc_b = $signed(state_r.acc_b) >>> op_count_i;
            end
            bfau_pkg::OP_SHIFT_LEFT_ACC_A: begin
              state_nxt.acc_a = state_r.acc_a << op_count_i;
            end
            bfau_pkg::OP_SIGNED_MULTIPLY: begin
              state_nxt.done  = 1'b0;
              state_nxt.fsm   = ST_MUL;
              state_nxt.mcand = {state_r.acc_a[15], state_r.acc_a};
              state_nxt.prod  = {17'h00000, state_r.acc_b, 1'b0};
              state_nxt.step  = 5'h00;
            end
            bfau_pkg::OP_MANT_ADD: begin
              state_nxt.bcd_y[47:0] = sum[47:0];
              state_nxt.dcarry      = sum[48];
            end
            bfau_pkg::OP_SKIP_IF_DCARRY_SET: begin
              state_nxt.skip = state_r.dcarry;
            end
            bfau_pkg::OP_SKIP_IF_DCARRY_CLEAR: begin
              state_nxt.skip = !state_r.dcarry;
            end
            bfau_pkg::OP_CLEAR_DCARRY: state_nxt.dcarry = 1'b0;
            bfau_pkg::OP_COMPLEMENT_FIRST_BCD_ACC: begin
              state_nxt.bcd_x[47:0] = comp_out;
              state_nxt.dcarry      = 1'b0;
            end
            bfau_pkg::OP_COMPLEMENT_SECOND_BCD_ACC: begin
              state_nxt.bcd_y[47:0] = comp_out;
              state_nxt.dcarry      = 1'b0;
            end
            default: state_nxt.done = 1'b1;
          endcase
        end
      end
      ST_MUL: begin
        // Booth recoding of the multiplier pair
        case (state_r.prod[1:0])
          2'b01:   upper = upper + state_r.mcand;
          2'b10:   upper = upper - state_r.mcand;
          default: upper = upper;
        endcase
        state_nxt.prod = {upper[16], upper, state_r.prod[16:1]};
        state_nxt.step = state_r.step + 5'h01;
        if (state_r.step == 5'(bfau_pkg::MUL_STEPS - 1)) begin
          state_nxt.acc_b = state_nxt.prod[32:17];
          state_nxt.acc_a = state_nxt.prod[16:1];
          state_nxt.done  = 1'b1;
          state_nxt.fsm   = ST_IDLE;
        end
      end
      default: state_nxt.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r        <= '0;
      state_r.fsm    <= ST_IDLE;
      state_r.acc_a  <= bfau_pkg::ACC_RST;
      state_r.acc_b  <= bfau_pkg::ACC_RST;
      state_r.bcd_x  <= bfau_pkg::BCD_RST;
      state_r.bcd_y  <= bfau_pkg::BCD_RST;
      state_r.dcarry <= bfau_pkg::DCARRY_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign acc_a_o              = state_r.acc_a;
  assign acc_b_o              = state_r.acc_b;
  assign first_bcd_acc_o      = state_r.bcd_x;
  assign second_bcd_acc_o     = state_r.bcd_y;
  assign decimal_carry_flag_o = state_r.dcarry;
  assign skip_o               = state_r.skip;
  assign done_o               = state_r.done;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  chk_sra_a_sign: assert property (
    op_fire && op_code_i == bfau_pkg::OP_SHIFT_RIGHT_SIGNED_ACC_A
    |=> $signed(acc_a_o) == ($signed($past(acc_a_o)) >>> $past(op_count_i)))
    else $error("acc a signed shift wrong");

  chk_sra_b_sign: assert property (
    op_fire && op_code_i == bfau_pkg::OP_SHIFT_RIGHT_SIGNED_ACC_B
    |=> acc_b_o[15] == $past(acc_b_o[15])
        && ((acc_b_o ^ {16{acc_b_o[15]}}) >> (4'hf - $past(op_count_i)))
           == 16'h0000)
    else $error("acc b sign not kept");

  chk_exp_extract: assert property (
    op_fire && op_code_i == bfau_pkg::OP_SHIFT_RIGHT_SIGNED_ACC_A
    && op_count_i == 4'h6
    |=> acc_a_o[9:0] == $past(acc_a_o[15:6])
        && acc_a_o[15:10] == {6{$past(acc_a_o[15])}})
    else $error("exponent not extracted");

  chk_mul_result: assert property (
    op_fire && op_code_i == bfau_pkg::OP_SIGNED_MULTIPLY
    |-> ##17 done_o && $signed({acc_b_o, acc_a_o}) ==
        $signed($past(acc_a_o, 17)) * $signed($past(acc_b_o, 17)))
    else $error("multiply result wrong");

  chk_add_carry_in: assert property (
    op_fire && op_code_i == bfau_pkg::OP_MANT_ADD
    && first_bcd_acc_o[47:0] == 48'h0 && decimal_carry_flag_o
    && second_bcd_acc_o[3:0] < 4'h9
    |=> second_bcd_acc_o[3:0] == $past(second_bcd_acc_o[3:0]) + 4'h1
        && !decimal_carry_flag_o)
    else $error("carry not added in");

  chk_comp_clear: assert property (
    op_fire && (op_code_i == bfau_pkg::OP_COMPLEMENT_FIRST_BCD_ACC ||
                op_code_i == bfau_pkg::OP_COMPLEMENT_SECOND_BCD_ACC)
    |=> !decimal_carry_flag_o)
    else $error("complement left carry set");

  chk_comp_exp: assert property (
    op_fire && op_code_i == bfau_pkg::OP_COMPLEMENT_FIRST_BCD_ACC
    |=> $stable(first_bcd_acc_o[63:48]) && $stable(second_bcd_acc_o))
    else $error("complement touched exponent");

  chk_comp_y_exp: assert property (
    op_fire && op_code_i == bfau_pkg::OP_COMPLEMENT_SECOND_BCD_ACC
    |=> $stable(second_bcd_acc_o[63:48]) && $stable(first_bcd_acc_o))
    else $error("complement touched second exponent");

  chk_comp_zero: assert property (
    op_fire && op_code_i == bfau_pkg::OP_COMPLEMENT_SECOND_BCD_ACC
    && second_bcd_acc_o[47:0] == 48'h0
    |=> second_bcd_acc_o[47:0] == 48'h0)
    else $error("zero mantissa changed");

  chk_comp_low: assert property (
    op_fire && op_code_i == bfau_pkg::OP_COMPLEMENT_FIRST_BCD_ACC
    && first_bcd_acc_o[3:0] != 4'h0
    |=> first_bcd_acc_o[3:0] == 4'ha - $past(first_bcd_acc_o[3:0])
        && first_bcd_acc_o[7:4] == 4'h9 - $past(first_bcd_acc_o[7:4]))
    else $error("complement digits wrong");

  chk_skip_set: assert property (
    op_fire && op_code_i == bfau_pkg::OP_SKIP_IF_DCARRY_SET
    |=> skip_o == $past(decimal_carry_flag_o)
        ##1 (!skip_o || $past(op_fire)))
    else $error("skip on set wrong");

  chk_clear_op: assert property (
    op_fire && op_code_i == bfau_pkg::OP_CLEAR_DCARRY
    |=> !decimal_carry_flag_o && done_o)
    else $error("carry not cleared");
endmodule
`default_nettype wire

// >>> logic/bfau_pkg.sv
`default_nettype none
package bfau_pkg;
  localparam int WORD_W      = 16;
  localparam int DIGIT_W     = 4;
  localparam int NUM_DIGITS  = 12;
  localparam int MANT_W      = NUM_DIGITS * DIGIT_W;
  localparam int BCD_W       = 4 * WORD_W;
  localparam int MUL_STEPS   = 16;
  localparam int EXP_SHIFT   = 6;
  // Exponent word fields
  localparam int EXP_SIGN_BIT = 15;
  localparam int EXP_MSB      = 15;
  localparam int EXP_LSB      = 6;
  localparam int TYPE_MSB     = 5;
  localparam int TYPE_LSB     = 1;
  localparam int MSIGN_BIT    = 0;
  localparam int EXP_WORD_MSB = BCD_W - 1;
  localparam int EXP_WORD_LSB = MANT_W;
  // Digit constants
  localparam logic [3:0] DIGIT_TEN  = 4'ha;
  localparam logic [3:0] DIGIT_NINE = 4'h9;
  // Reset values
  localparam logic [15:0] ACC_RST   = 16'h0000;
  localparam logic [63:0] BCD_RST   = 64'h0000_0000_0000_0000;
  localparam logic        DCARRY_RST = 1'b0;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_LOAD_A,
    OP_LOAD_B,
    OP_LOAD_X,
    OP_LOAD_Y,
    OP_SHIFT_RIGHT_SIGNED_ACC_A,
    OP_SHIFT_RIGHT_SIGNED_ACC_B,
    OP_SHIFT_LEFT_ACC_A,
    OP_SIGNED_MULTIPLY,
    OP_MANT_ADD,
    OP_SKIP_IF_DCARRY_SET,
    OP_SKIP_IF_DCARRY_CLEAR,
    OP_CLEAR_DCARRY,
    OP_COMPLEMENT_FIRST_BCD_ACC,
    OP_COMPLEMENT_SECOND_BCD_ACC
  } bfau_op_t;
endpackage
`default_nettype wire

// >>> logic/bfau_tens_comp.sv
`default_nettype none
module bfau_tens_comp #(
  parameter int NUM_DIGITS = bfau_pkg::NUM_DIGITS
) (
  // Mantissa in
  input  wire logic [NUM_DIGITS*4-1:0] mant_i,
  // Complemented mantissa out
  output logic      [NUM_DIGITS*4-1:0] comp_o
);
  always_comb begin
    logic       seen;
    logic [3:0] d;
    seen   = 1'b0;
    d      = 4'h0;
    comp_o = '0;
    // Walk from the lowest digit upward
    for (int i = 0; i < NUM_DIGITS; i++) begin
      d = mant_i[i*4 +: 4];
      if (seen) begin
        comp_o[i*4 +: 4] = bfau_pkg::DIGIT_NINE - d;
      end else if (d != 4'h0) begin
        comp_o[i*4 +: 4] = bfau_pkg::DIGIT_TEN - d;
        seen             = 1'b1;
      end else begin
        comp_o[i*4 +: 4] = 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/bfau_host.sv
`default_nettype none
module bfau_host (
  // Clock and design answers
  input  wire logic              clk_sys_i,
  input  wire logic              op_ready_i,
  input  wire logic              done_i,
  input  wire logic              skip_i,
  // Instruction request
  output var logic               op_valid_o,
  output var bfau_pkg::bfau_op_t op_code_o,
  output var logic [3:0]         op_count_o,
  output var logic [1:0]         op_index_o,
  output var logic [15:0]        op_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    op_valid_o = 1'b0;
    op_code_o = bfau_pkg::OP_NOP;
    op_count_o = 4'h0;
    op_index_o = 2'h0;
    op_data_o = 16'h0000;
  end
  // Request held until taken; released count, index and data lines show inverted values, op code kept
  task automatic issue(input bfau_pkg::bfau_op_t op, input logic [3:0] cnt,
      input logic [1:0] idx, input logic [15:0] dat, output logic skp,
      output logic ok);
    int n;
    n = 0;
    @(posedge clk_sys_i) #1;
    while (op_ready_i !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i) #1;
      n++;
    end
    op_valid_o = 1'b1;
    op_code_o = op;
    op_count_o = cnt;
    op_index_o = idx;
    op_data_o = dat;
    @(posedge clk_sys_i) #1;
    op_valid_o = 1'b0;
    op_count_o = ~cnt;
    op_index_o = ~idx;
    op_data_o = ~dat;
    while (done_i !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i) #1;
      n++;
    end
    skp = skip_i;
    ok = (n < 40);
  endtask
endmodule
`default_nettype wire

// >>> tb/bcd_float_arith_unit_test.sv
`default_nettype none
module bcd_float_arith_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint T12 = 64'he8d4a51000;
  logic clk_sys_i, reset_n_i, op_valid, op_ready, dc, skp, done;
  bfau_pkg::bfau_op_t op_code;
  logic [3:0] op_count;
  logic [1:0] op_index;
  logic [15:0] op_data, acc_a, acc_b, m_a, m_b, ew;
  logic [63:0] x, y, m_x, m_y;
  logic m_dc;
  int mismatches, tests_run, cycles;
  bfau_core bfau_core_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .op_valid_i(op_valid), .op_code_i(op_code), .op_count_i(op_count),
    .op_index_i(op_index), .op_data_i(op_data), .op_ready_o(op_ready),
    .acc_a_o(acc_a), .acc_b_o(acc_b), .first_bcd_acc_o(x),
    .second_bcd_acc_o(y), .decimal_carry_flag_o(dc), .skip_o(skp),
    .done_o(done));
  bfau_host bfau_host_inst (.clk_sys_i(clk_sys_i), .op_ready_i(op_ready),
    .done_i(done), .skip_i(skp), .op_valid_o(op_valid),
    .op_code_o(op_code), .op_count_o(op_count), .op_index_o(op_index),
    .op_data_o(op_data));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      test_done();
    end
  end
  function automatic longint b2i(input logic [47:0] m);
    longint v;
    v = 0;
    for (int i = 11; i >= 0; i--) v = v * 10 + m[i*4+:4];
    return v;
  endfunction
  function automatic logic [47:0] i2b(input longint v);
    logic [47:0] m;
    for (int i = 0; i < 12; i++) begin
      m[i*4+:4] = 4'(v % 10);
      v = v / 10;
    end
    return m;
  endfunction
  function automatic logic [63:0] rnum(input int tz);
    logic [63:0] m;
    m[63:48] = 16'($urandom);
    for (int d = 0; d < 12; d++)
      m[d*4+:4] = (d < tz) ? 4'h0 : 4'($urandom % 10);
    return m;
  endfunction
  task automatic run(input bfau_pkg::bfau_op_t op, input logic [3:0] c,
      input logic [1:0] ix, input logic [15:0] d);
    logic s, ok, ms;
    logic signed [31:0] p;
    longint sum;
    bfau_host_inst.issue(op, c, ix, d, s, ok);
    check(64'(ok), 64'h1);
    ms = 1'bx;
    case (op)
      bfau_pkg::OP_LOAD_A: m_a = d;
      bfau_pkg::OP_LOAD_B: m_b = d;
      bfau_pkg::OP_LOAD_X: m_x[ix*16+:16] = d;
      bfau_pkg::OP_LOAD_Y: m_y[ix*16+:16] = d;
      bfau_pkg::OP_SHIFT_RIGHT_SIGNED_ACC_A: m_a = $signed(m_a) >>> c;
      bfau_pkg::OP_SHIFT_RIGHT_SIGNED_ACC_B: m_b = $signed(m_b) >>> c;
      bfau_pkg::OP_SHIFT_LEFT_ACC_A: m_a = m_a << c;
      bfau_pkg::OP_SIGNED_MULTIPLY: begin
        p = $signed(m_a) * $signed(m_b);
        {m_b, m_a} = p;
      end
      bfau_pkg::OP_MANT_ADD: begin
        sum = b2i(m_x[47:0]) + b2i(m_y[47:0]) + 64'(m_dc);
        m_y[47:0] = i2b(sum % T12);
        m_dc = (sum >= T12);
      end
      bfau_pkg::OP_SKIP_IF_DCARRY_SET: ms = m_dc;
      bfau_pkg::OP_SKIP_IF_DCARRY_CLEAR: ms = ~m_dc;
      bfau_pkg::OP_CLEAR_DCARRY: m_dc = 1'b0;
      bfau_pkg::OP_COMPLEMENT_FIRST_BCD_ACC: begin
        m_x[47:0] = i2b((T12 - b2i(m_x[47:0])) % T12);
        m_dc = 1'b0;
      end
      bfau_pkg::OP_COMPLEMENT_SECOND_BCD_ACC: begin
        m_y[47:0] = i2b((T12 - b2i(m_y[47:0])) % T12);
        m_dc = 1'b0;
      end
      default: ;
    endcase
    check(64'(acc_a), 64'(m_a));
    check(64'(acc_b), 64'(m_b));
    check(x, m_x);
    check(y, m_y);
    check(64'(dc), 64'(m_dc));
    if (ms !== 1'bx) check(64'(s), 64'(ms));
  endtask
  task automatic load(input logic sec, input logic [63:0] v);
    for (int w = 0; w < 4; w++)
      run(sec ? bfau_pkg::OP_LOAD_Y : bfau_pkg::OP_LOAD_X, 4'h0, 2'(w),
          v[w*16+:16]);
  endtask
  initial begin
    reset_n_i = 1'b0;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    {m_a, m_b, m_x, m_y, m_dc} = '0;
    void'($urandom(32'hc2d4));
    repeat (10) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    check({acc_a, acc_b, 30'h0, dc, op_ready}, 64'h1);
    check(x | y, 64'h0);
    run(bfau_pkg::OP_NOP, 4'h0, 2'h0, 16'h0000);
    for (int k = 0; k < 16; k++) begin
      run(bfau_pkg::OP_LOAD_A, 4'h0, 2'h0, 16'($urandom));
      run(bfau_pkg::OP_LOAD_B, 4'h0, 2'h0, 16'($urandom) | 16'h8000);
      run(bfau_pkg::OP_SHIFT_RIGHT_SIGNED_ACC_A, 4'(k), 2'h0, 16'h0000);
      run(bfau_pkg::OP_SHIFT_RIGHT_SIGNED_ACC_B, 4'(k), 2'h0, 16'h0000);
      run(bfau_pkg::OP_SHIFT_LEFT_ACC_A, 4'(15 - k), 2'h0, 16'h0000);
    end
    $display("shift test done");
    for (int k = 0; k < 8; k++) begin
      ew = (k == 0) ? 16'h8000 : (k == 1) ? 16'h7fff : 16'($urandom);
      run(bfau_pkg::OP_LOAD_A, 4'h0, 2'h0, ew);
      run(bfau_pkg::OP_SHIFT_RIGHT_SIGNED_ACC_A, 4'h6, 2'h0, 16'h0000);
      check(64'(acc_a), 64'({{6{ew[15]}}, ew[15:6]}));
    end
    $display("exponent test done");
    for (int k = 0; k < 8; k++) begin
      run(bfau_pkg::OP_LOAD_A, 4'h0, 2'h0, (k < 2) ? 16'h8000 : 16'($urandom));
      run(bfau_pkg::OP_LOAD_B, 4'h0, 2'h0, (k == 0) ? 16'h8000 : 16'($urandom));
      run(bfau_pkg::OP_SIGNED_MULTIPLY, 4'h0, 2'h0, 16'h0000);
    end
    $display("multiply test done");
    for (int k = 0; k < 12; k++) begin
      load(1'b0, rnum((k == 0) ? 12 : k));
      load(1'b1, rnum(11 - k));
      run(bfau_pkg::OP_MANT_ADD, 4'h0, 2'h0, 16'h0000);
      run(bfau_pkg::OP_SKIP_IF_DCARRY_SET, 4'h0, 2'h0, 16'h0000);
      run(bfau_pkg::OP_SKIP_IF_DCARRY_CLEAR, 4'h0, 2'h0, 16'h0000);
      if (k[0]) run(bfau_pkg::OP_CLEAR_DCARRY, 4'h0, 2'h0, 16'h0000);
      run(bfau_pkg::OP_COMPLEMENT_FIRST_BCD_ACC, 4'h0, 2'h0, 16'h0000);
      run(bfau_pkg::OP_MANT_ADD, 4'h0, 2'h0, 16'h0000);
      run(bfau_pkg::OP_COMPLEMENT_SECOND_BCD_ACC, 4'h0, 2'h0, 16'h0000);
    end
    $display("bcd test done");
    // Overflow sets carry, carry then added in at lowest digit
    load(1'b0, {16'h8421, 48'h9999_9999_9999});
    load(1'b1, 64'h0000_0000_0000_0001);
    run(bfau_pkg::OP_MANT_ADD, 4'h0, 2'h0, 16'h0000);
    check(64'(dc), 64'h1);
    run(bfau_pkg::OP_SKIP_IF_DCARRY_SET, 4'h0, 2'h0, 16'h0000);
    run(bfau_pkg::OP_SKIP_IF_DCARRY_CLEAR, 4'h0, 2'h0, 16'h0000);
    load(1'b0, 64'h0);
    run(bfau_pkg::OP_MANT_ADD, 4'h0, 2'h0, 16'h0000);
    check(y[47:0], 48'h0000_0000_0001);
    load(1'b1, {16'hc03f, 48'h0});
    run(bfau_pkg::OP_COMPLEMENT_SECOND_BCD_ACC, 4'h0, 2'h0, 16'h0000);
    check(y, {16'hc03f, 48'h0});
    $display("carry test done");
    test_done();
  end
endmodule
`default_nettype wire
